// ==== src/rsc_pkg.sv ====
// Register map, field layout, states and timing of the radio state controller
package rsc_pkg;

	// ==========================================
	// Register offsets
	localparam logic [7:0] RSC_OFF_CMD   = 8'h00;
	localparam logic [7:0] RSC_OFF_CFG   = 8'h04;
	localparam logic [7:0] RSC_OFF_WAKE  = 8'h08;
	localparam logic [7:0] RSC_OFF_RXT   = 8'h0c;
	localparam logic [7:0] RSC_OFF_STAT  = 8'h10;
	localparam logic [7:0] RSC_OFF_DATA  = 8'h14;
	localparam logic [7:0] RSC_OFF_SBYTE = 8'h18;

	// ==========================================
	// Command bits
	localparam int RSC_CMD_RX  = 0;
	localparam int RSC_CMD_TX  = 1;
	localparam int RSC_CMD_IDL = 2;
	localparam int RSC_CMD_CAL = 3;
	localparam int RSC_CMD_WOR = 4;
	localparam int RSC_CMD_SYN = 5;

	// ==========================================
	// Configuration fields and reset values
	localparam int RSC_CFG_AUTOCAL = 0;
	localparam int RSC_CFG_AFT_RX  = 2;
	localparam int RSC_CFG_AFT_TX  = 4;
	localparam int RSC_CFG_CCA     = 6;
	localparam int RSC_CFG_QUAL    = 8;
	localparam int RSC_CFG_NOCAR   = 9;
	localparam int RSC_CFG_THR     = 10;
	localparam int RSC_CFG_EXP     = 14;
	localparam int RSC_CFG_PD      = 16;
	localparam int RSC_WAKE_E1     = 16;
	localparam logic [16:0] RSC_CFG_RST  = 17'h10000;
	localparam logic [31:0] RSC_WAKE_RST = 32'h0000_0000;
	localparam logic [15:0] RSC_RXT_RST  = 16'h0000;

	// Status flag positions, write one to clear
	localparam int RSC_ST_WK0 = 4;
	localparam int RSC_ST_WK1 = 5;
	localparam int RSC_ST_OVF = 6;
	localparam int RSC_ST_UDF = 7;

	// ==========================================
	// Setting codes
	localparam logic [1:0] RSC_CAL_LEAVE = 2'h1;
	localparam logic [1:0] RSC_CAL_RET   = 2'h2;
	localparam logic [1:0] RSC_CAL_RET4  = 2'h3;
	localparam logic [1:0] RSC_AFT_FSTX  = 2'h1;
	localparam logic [1:0] RSC_AFT_TX    = 2'h2;
	localparam logic [1:0] RSC_AFT_RX    = 2'h3;

	// ==========================================
	// Transition times in crystal periods
	localparam logic [14:0] RSC_T_IDLE_ACT = 15'h08fa;
	localparam logic [14:0] RSC_T_TX_RX    = 15'h0230;
	localparam logic [14:0] RSC_T_RX_TX    = 15'h00fa;
	localparam logic [14:0] RSC_T_ACT_IDLE = 15'h0002;
	localparam logic [14:0] RSC_T_MIN      = 15'h0001;
	localparam int          RSC_T_IDLE_CAL = 32'h0000_522d;
	localparam int          RSC_T_CAL      = 32'h0000_4933;

	// ==========================================
	// FIFOs
	localparam int         RSC_FIFO_N      = 64;
	localparam logic [6:0] RSC_FIFO_FULL   = 7'h40;
	localparam logic [6:0] RSC_THR_TX_BASE = 7'h3d;

	typedef enum logic [2:0] {
		RSC_SLEEP  = 3'b000,
		RSC_IDLE   = 3'b001,
		RSC_SETTLE = 3'b010,
		RSC_RX     = 3'b011,
		RSC_TX     = 3'b100,
		RSC_FSTX   = 3'b101
	} rsc_state_e;

	// Events and data from the radio datapath
	typedef struct packed {
		logic       rx_pkt_ok;
		logic       tx_pkt_done;
		logic       sync_found;
		logic       pq_above;
		logic       cs_valid;
		logic       carrier;
		logic       rssi_below;
		logic       pkt_active;
		logic       rx_byte_valid;
		logic [7:0] rx_byte;
		logic       tx_byte_req;
	} rsc_evt_s;

endpackage

// ==== src/rsc_radio_ctrl.sv ====
// Radio state controller with wake timer, RX termination timer, data FIFOs and APB registers
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Receive strobe enters RX, transmit strobe enters TX; each entry passes through SETTLE.
// - Auto calibration on leaving IDLE, on auto return, or every fourth return.
// - RX holds until packet received or termination timer ends it.
// - After a packet, after-receive setting picks IDLE, synth-on, TX or RX.
// - TX holds until packet sent, then after-transmit setting picks destination.
// - Receive strobe during TX ends transmission and switches to RX.
// - TX or synth strobe in RX needs clear channel; else stay, no retry.
// - Idle strobe forces IDLE from every state.
// - Wake strobe in IDLE enters SLEEP, clears wake power-down, starts wake timer.
// - Wake timer gives event 0 then event 1; each sets its flag.
// - Event 0 period is mantissa times two to five times exponent.
// - Event 1 moves SLEEP to RX without a strobe.
// - RX timer expiry continues only on sync, or sync/preamble quality.
// - No-carrier option ends RX on first valid sample without carrier.
// - Timeout or no-carrier end goes IDLE, or SLEEP with wake timer on.
// - Fixed transition times: 2298, 21037, 560, 250 and 2 periods.
// - Strobed and return calibrations take 18739 crystal periods; calibration on leaving IDLE takes 21037.
// - Two 64-byte FIFOs; RX overflow and TX underflow detected.
// - Status byte shows RX fill on reads, TX fill on writes.
// - Four-bit code picks threshold; signal high at or above it.
module rsc_radio_ctrl
	import rsc_pkg::*;
#(
	parameter int T_IDLE_CAL = RSC_T_IDLE_CAL,
	parameter int T_CAL      = RSC_T_CAL
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire rsc_evt_s    radio_ev,
	input  wire logic        aux_clk_pin,
	output var rsc_state_e   radio_state,
	output logic             calibrating,
	output logic             radio_ready_low,
	output logic             wake_wake_period_mantissa_flag,
	output logic             wake_second_event_timeout_flag,
	output logic             rx_fifo_threshold_code,
	output logic             tx_fifo_threshold_code,
	output logic [7:0]       tx_byte,
	output logic             tx_byte_valid
);

	localparam logic [14:0] T_IDLE_CAL_M1 = 15'(T_IDLE_CAL - 1);
	localparam logic [14:0] T_CAL_M1      = 15'(T_CAL - 1);

	// ==========================================
	// Decode functions
	function automatic rsc_state_e aft_dest(input logic [1:0] code);
		case (code)
			RSC_AFT_FSTX: aft_dest = RSC_FSTX;
			RSC_AFT_TX:   aft_dest = RSC_TX;
			RSC_AFT_RX:   aft_dest = RSC_RX;
			default:      aft_dest = RSC_IDLE;
		endcase
	endfunction

	function automatic logic [14:0] turn_delay(input rsc_state_e from, input rsc_state_e to);
		if (from == RSC_TX && to == RSC_RX) begin
			turn_delay = RSC_T_TX_RX;
		end else if (from == RSC_RX) begin
			turn_delay = RSC_T_RX_TX;
		end else begin
			turn_delay = RSC_T_MIN;
		end
	endfunction

	// ==========================================
	// Declarations
	rsc_state_e  state_r, state_nxt, tgt_r, tgt_nxt, dst;
	logic [14:0] tmr_r, tmr_nxt;
	logic        cal_r, cal_nxt, ret_auto, rx_start, lv;
	logic [1:0]  ret_cnt_r;
	logic [16:0] cfg_r;
	logic [31:0] wake_r;
	logic [15:0] rxt_cfg_r, rxt_cnt_r;
	logic        rxt_run_r, cs_seen_r;
	logic        aux_m_r, aux_s_r, aux_d_r;
	logic [31:0] wk_cnt_r;
	logic [7:0]  e1_cnt_r;
	logic        e1_run_r;
	logic        wk0_f_r, wk1_f_r, ovf_r, udf_r;
	logic        rdy_low_r, rx_thr_r, tx_thr_r;
	logic [7:0]  sbyte_r, tx_byte_r;
	logic        tx_vld_r;
	logic [31:0] prdata_r;
	logic        pready_r, pslverr_r;

	// ==========================================
	// APB decode
	wire setup    = psel & ~penable;
	wire acc      = psel & penable & pready_r;
	wire hit_cmd  = paddr == RSC_OFF_CMD;
	wire hit_cfg  = paddr == RSC_OFF_CFG;
	wire hit_wake = paddr == RSC_OFF_WAKE;
	wire hit_rxt  = paddr == RSC_OFF_RXT;
	wire hit_stat = paddr == RSC_OFF_STAT;
	wire hit_data = paddr == RSC_OFF_DATA;
	wire hit_sb   = paddr == RSC_OFF_SBYTE;
	wire addr_ok  = hit_cmd | hit_cfg | hit_wake | hit_rxt | hit_stat | hit_data | hit_sb;
	wire wr       = acc & pwrite & addr_ok;
	wire wr_cmd   = wr & hit_cmd;
	wire wr_stat  = wr & hit_stat;
	wire wr_data  = wr & hit_data;
	wire rd_pop   = acc & ~pwrite & hit_data;

	// Strobes; idle outranks every other strobe of the same write
	wire s_idle = wr_cmd & pwdata[RSC_CMD_IDL];
	wire s_wor  = wr_cmd & pwdata[RSC_CMD_WOR];
	wire s_cal  = wr_cmd & pwdata[RSC_CMD_CAL];
	wire s_rx   = wr_cmd & pwdata[RSC_CMD_RX];
	wire s_tx   = wr_cmd & pwdata[RSC_CMD_TX];
	wire s_syn  = wr_cmd & pwdata[RSC_CMD_SYN];

	// ==========================================
	// Settings
	wire [1:0] autocal   = cfg_r[RSC_CFG_AUTOCAL +: 2];
	wire [1:0] after_rx  = cfg_r[RSC_CFG_AFT_RX +: 2];
	wire [1:0] after_tx  = cfg_r[RSC_CFG_AFT_TX +: 2];
	wire [1:0] cca_rule  = cfg_r[RSC_CFG_CCA +: 2];
	wire [3:0] thr_code  = cfg_r[RSC_CFG_THR +: 4];
	wire [1:0] wk_exp    = cfg_r[RSC_CFG_EXP +: 2];
	wire       wor_on    = ~cfg_r[RSC_CFG_PD];
	wire       wor_go    = s_wor & ~s_idle & (state_r == RSC_IDLE);
	wire       lv_cal    = autocal == RSC_CAL_LEAVE;
	wire       ret_cal   = (autocal == RSC_CAL_RET) |
	                       ((autocal == RSC_CAL_RET4) & (ret_cnt_r == 2'h3));

	// Clear channel check: bit 0 needs RSSI below threshold, bit 1 no packet in progress
	wire cca_ok = (~cca_rule[0] | radio_ev.rssi_below) & (~cca_rule[1] | ~radio_ev.pkt_active);

	// ==========================================
	// RX termination
	wire stay_q  = radio_ev.sync_found | (cfg_r[RSC_CFG_QUAL] & radio_ev.pq_above);
	wire rxt_exp = rxt_run_r & (rxt_cnt_r == 16'h0001) & (state_r == RSC_RX);
	wire no_car  = cfg_r[RSC_CFG_NOCAR] & radio_ev.cs_valid & ~cs_seen_r & ~radio_ev.carrier;
	wire rx_term = (rxt_exp & ~stay_q) | no_car;

	// ==========================================
	// Wake timer decode
	wire [3:0]  wk_shift  = {wk_exp, 2'b00} + {2'b00, wk_exp};
	wire [31:0] wk_period = {16'h0000, wake_r[15:0]} << wk_shift;
	wire        aux_tick  = aux_s_r & ~aux_d_r;
	wire        wk_ev0    = aux_tick & wor_on & ~wor_go & (wk_cnt_r >= wk_period - 32'h1);
	wire        wk_ev1    = aux_tick & wor_on & ~wor_go & e1_run_r & (e1_cnt_r == 8'h00);

	// ==========================================
	// State machine
	always_comb begin
		state_nxt = state_r;
		tgt_nxt   = tgt_r;
		tmr_nxt   = (tmr_r != 15'h0) ? tmr_r - 15'h1 : tmr_r;
		cal_nxt   = cal_r;
		ret_auto  = 1'b0;
		rx_start  = 1'b0;
		lv        = 1'b0;
		dst       = RSC_IDLE;
		if (s_idle) begin
			state_nxt = RSC_IDLE;
			tmr_nxt   = 15'h0;
			cal_nxt   = 1'b0;
		end else begin
			case (state_r)
				RSC_SLEEP: begin
					if (wk_ev1) begin
						state_nxt = RSC_SETTLE;
						tgt_nxt   = RSC_RX;
						tmr_nxt   = RSC_T_IDLE_ACT - 15'h1;
					end
				end
				RSC_IDLE: begin
					if (wor_go) begin
						state_nxt = RSC_SLEEP;
					end else if (s_cal) begin
						state_nxt = RSC_SETTLE;
						tgt_nxt   = RSC_IDLE;
						tmr_nxt   = T_CAL_M1;
						cal_nxt   = 1'b1;
					end else if (s_rx | s_tx | s_syn) begin
						state_nxt = RSC_SETTLE;
						tgt_nxt   = s_rx ? RSC_RX : (s_tx ? RSC_TX : RSC_FSTX);
						tmr_nxt   = lv_cal ? T_IDLE_CAL_M1 : RSC_T_IDLE_ACT - 15'h1;
						cal_nxt   = lv_cal;
					end
				end
				RSC_SETTLE: begin
					if (tmr_r == 15'h0) begin
						state_nxt = tgt_r;
						cal_nxt   = 1'b0;
						rx_start  = tgt_r == RSC_RX;
					end
				end
				RSC_FSTX: begin
					lv  = s_rx | s_tx;
					dst = s_rx ? RSC_RX : RSC_TX;
				end
				RSC_RX: begin
					lv = 1'b1;
					if (radio_ev.rx_pkt_ok) begin
						dst = aft_dest(after_rx);
					end else if (rx_term) begin
						dst = wor_on ? RSC_SLEEP : RSC_IDLE;
					end else if ((s_tx | s_syn) & cca_ok) begin
						dst = s_tx ? RSC_TX : RSC_FSTX;
					end else begin
						lv = 1'b0;
					end
				end
				RSC_TX: begin
					lv = 1'b1;
					if (s_rx) begin
						dst = RSC_RX;
					end else if (radio_ev.tx_pkt_done) begin
						dst = aft_dest(after_tx);
					end else begin
						lv = 1'b0;
					end
				end
				default: begin
					state_nxt = RSC_IDLE;
				end
			endcase
			if (lv) begin
				if (dst == RSC_IDLE) begin
					ret_auto = 1'b1;
				end else if (dst == state_r) begin
					rx_start = dst == RSC_RX;
				end else if (dst == RSC_SLEEP) begin
					state_nxt = RSC_SLEEP;
				end else begin
					state_nxt = RSC_SETTLE;
					tgt_nxt   = dst;
					tmr_nxt   = turn_delay(state_r, dst) - 15'h1;
				end
			end
			if (ret_auto) begin
				state_nxt = RSC_SETTLE;
				tgt_nxt   = RSC_IDLE;
				tmr_nxt   = ret_cal ? T_CAL_M1 : RSC_T_ACT_IDLE - 15'h1;
				cal_nxt   = ret_cal;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= RSC_SLEEP;
			tgt_r     <= RSC_IDLE;
			tmr_r     <= 15'h0;
			cal_r     <= 1'b0;
			ret_cnt_r <= 2'h0;
			rdy_low_r <= 1'b1;
		end else begin
			state_r   <= state_nxt;
			tgt_r     <= tgt_nxt;
			tmr_r     <= tmr_nxt;
			cal_r     <= cal_nxt;
			ret_cnt_r <= ret_cnt_r + {1'b0, ret_auto};
			rdy_low_r <= state_nxt == RSC_SLEEP;
		end
	end

	// ==========================================
	// RX termination timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxt_cnt_r <= 16'h0;
			rxt_run_r <= 1'b0;
			cs_seen_r <= 1'b0;
		end else if (rx_start) begin
			rxt_cnt_r <= rxt_cfg_r;
			rxt_run_r <= rxt_cfg_r != 16'h0;
			cs_seen_r <= 1'b0;
		end else begin
			rxt_cnt_r <= (rxt_cnt_r != 16'h0) ? rxt_cnt_r - 16'h1 : rxt_cnt_r;
			rxt_run_r <= rxt_run_r & ~rxt_exp & (state_r == RSC_RX);
			cs_seen_r <= cs_seen_r | ((state_r == RSC_RX) & radio_ev.cs_valid);
		end
	end

	// ==========================================
	// Wake timer on the auxiliary clock pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_m_r <= 1'b0;
			aux_s_r <= 1'b0;
			aux_d_r <= 1'b0;
		end else begin
			aux_m_r <= aux_clk_pin;
			aux_s_r <= aux_m_r;
			aux_d_r <= aux_s_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wk_cnt_r <= 32'h0;
			e1_cnt_r <= 8'h0;
			e1_run_r <= 1'b0;
		end else if (wor_go | ~wor_on) begin
			wk_cnt_r <= 32'h0;
			e1_run_r <= 1'b0;
		end else if (aux_tick) begin
			wk_cnt_r <= wk_ev0 ? 32'h0 : wk_cnt_r + 32'h1;
			if (wk_ev0) begin
				e1_cnt_r <= wake_r[RSC_WAKE_E1 +: 8];
				e1_run_r <= 1'b1;
			end else if (e1_run_r) begin
				e1_cnt_r <= e1_cnt_r - 8'h1;
				e1_run_r <= e1_cnt_r != 8'h00;
			end
		end
	end

	// ==========================================
	// FIFOs: index 0 receive, index 1 transmit
	wire [1:0] f_push, f_pop, f_ok;
	wire [7:0] f_din  [2];
	wire [7:0] f_head [2];
	wire [6:0] f_cnt  [2];

	assign f_push[0] = radio_ev.rx_byte_valid;
	assign f_din[0]  = radio_ev.rx_byte;
	assign f_pop[0]  = rd_pop;
	assign f_push[1] = wr_data;
	assign f_din[1]  = pwdata[7:0];
	assign f_pop[1]  = radio_ev.tx_byte_req;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_fifo
			logic [7:0] mem_r [RSC_FIFO_N];
			logic [5:0] wp_r, rp_r;
			logic [6:0] cnt_r;
			wire        pop_ok  = f_pop[i] & (cnt_r != 7'h0);
			wire        push_ok = f_push[i] & ((cnt_r != RSC_FIFO_FULL) | pop_ok);

			always_ff @(posedge pclk) begin
				if (push_ok) begin
					mem_r[wp_r] <= f_din[i];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					wp_r  <= 6'h0;
					rp_r  <= 6'h0;
					cnt_r <= 7'h0;
				end else begin
					wp_r  <= wp_r + {5'h0, push_ok};
					rp_r  <= rp_r + {5'h0, pop_ok};
					cnt_r <= cnt_r + {6'h0, push_ok} - {6'h0, pop_ok};
				end
			end

			assign f_ok[i]   = push_ok;
			assign f_head[i] = mem_r[rp_r];
			assign f_cnt[i]  = cnt_r;
		end
	endgenerate

	wire [6:0] rx_pt    = {{1'b0, thr_code} + 5'h01, 2'b00};
	wire [6:0] tx_pt    = RSC_THR_TX_BASE - {1'b0, thr_code, 2'b00};
	wire       ovf_set  = f_push[0] & ~f_ok[0];
	wire       udf_set  = f_pop[1] & (f_cnt[1] == 7'h0);

	// ==========================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r     <= RSC_CFG_RST;
			wake_r    <= RSC_WAKE_RST;
			rxt_cfg_r <= RSC_RXT_RST;
			wk0_f_r   <= 1'b0;
			wk1_f_r   <= 1'b0;
			ovf_r     <= 1'b0;
			udf_r     <= 1'b0;
			sbyte_r   <= 8'h0;
			rx_thr_r  <= 1'b0;
			tx_thr_r  <= 1'b0;
			tx_byte_r <= 8'h0;
			tx_vld_r  <= 1'b0;
		end else begin
			if (wr & hit_cfg) begin
				cfg_r <= pwdata[16:0];
			end
			if (wor_go) begin
				cfg_r[RSC_CFG_PD] <= 1'b0;
			end
			if (wr & hit_wake) begin
				wake_r <= pwdata;
			end
			if (wr & hit_rxt) begin
				rxt_cfg_r <= pwdata[15:0];
			end
			wk0_f_r  <= (wk0_f_r & ~(wr_stat & pwdata[RSC_ST_WK0])) | wk_ev0;
			wk1_f_r  <= (wk1_f_r & ~(wr_stat & pwdata[RSC_ST_WK1])) | wk_ev1;
			ovf_r    <= (ovf_r & ~(wr_stat & pwdata[RSC_ST_OVF])) | ovf_set;
			udf_r    <= (udf_r & ~(wr_stat & pwdata[RSC_ST_UDF])) | udf_set;
			if (acc) begin
				sbyte_r <= {pwrite, pwrite ? f_cnt[1] : f_cnt[0]};
			end
			rx_thr_r  <= f_cnt[0] >= rx_pt;
			tx_thr_r  <= f_cnt[1] >= tx_pt;
			tx_vld_r  <= f_pop[1] & (f_cnt[1] != 7'h0);
			if (f_pop[1] & (f_cnt[1] != 7'h0)) begin
				tx_byte_r <= f_head[1];
			end
		end
	end

	// ==========================================
	// APB answer: one wait-free access phase, read data captured in setup
	wire [31:0] stat_word = {6'h0, rdy_low_r, tx_thr_r, rx_thr_r, f_cnt[1], 1'b0, f_cnt[0],
	                         udf_r, ovf_r, wk1_f_r, wk0_f_r, cal_r, state_r};
	wire [31:0] rd_mux = hit_cfg  ? {15'h0, cfg_r} :
	                     hit_wake ? wake_r :
	                     hit_rxt  ? {16'h0, rxt_cfg_r} :
	                     hit_stat ? stat_word :
	                     hit_data ? {24'h0, f_head[0]} :
	                     hit_sb   ? {24'h0, sbyte_r} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & ~addr_ok;
			if (setup & ~pwrite) begin
				prdata_r <= rd_mux;
			end
		end
	end

	// ==========================================
	// Outputs
	assign prdata           = prdata_r;
	assign pready           = pready_r;
	assign pslverr          = pslverr_r;
	assign radio_state      = state_r;
	assign calibrating      = cal_r;
	assign radio_ready_low  = rdy_low_r;
	assign wake_wake_period_mantissa_flag = wk0_f_r;
	assign wake_second_event_timeout_flag = wk1_f_r;
	assign rx_fifo_threshold_code      = rx_thr_r;
	assign tx_fifo_threshold_code      = tx_thr_r;
	assign tx_byte          = tx_byte_r;
	assign tx_byte_valid    = tx_vld_r;

endmodule

`default_nettype wire

// ==== bench/rsc_radio_model.sv ====
// Radio datapath model driving packet, carrier and FIFO events
`timescale 1ns/100ps
`default_nettype none
module rsc_radio_model
	import rsc_pkg::*;
(
	input  wire logic pclk,
	output var rsc_evt_s ev
);
	initial ev = '0;

	// ==========================================
	// One-cycle pulse of the given fields; the byte lines then show the inverse
	task automatic pulse(input rsc_evt_s p);
		rsc_evt_s nx;
		@(posedge pclk);
		nx = ev | p;
		nx.rx_byte = p.rx_byte;
		ev <= nx;
		@(posedge pclk);
		nx = ev & ~p;
		nx.rx_byte = ~p.rx_byte;
		ev <= nx;
	endtask

	// Levels for the clear-channel check and the timeout qualifier
	task automatic level(input logic quiet, input logic busy, input logic sync);
		@(posedge pclk);
		ev.rssi_below <= quiet;
		ev.pkt_active <= busy;
		ev.sync_found <= sync;
	endtask
endmodule
`default_nettype wire

// ==== bench/rsc_monitor.sv ====
// Assertion checker for the radio state controller ports
`timescale 1ns/100ps
`default_nettype none
module rsc_monitor
	import rsc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire rsc_evt_s    radio_ev,
	input wire rsc_state_e  radio_state,
	input wire logic        radio_ready_low,
	input wire logic        wake_wake_period_mantissa_flag,
	input wire logic        tx_byte_valid
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================
	// Completed register writes
	wire       wr_ok = psel && penable && pready && pwrite;
	wire [5:0] cmd   = (wr_ok && paddr == RSC_OFF_CMD) ? pwdata[5:0] : 6'h00;
	wire       clr0  = wr_ok && paddr == RSC_OFF_STAT && pwdata[RSC_ST_WK0];

	chk_idle_force: assert property (cmd[RSC_CMD_IDL] |=> radio_state == RSC_IDLE)
		else $error("idle strobe missed idle");
	chk_rx_enter: assert property (radio_state == RSC_IDLE && cmd == 6'h01 |=> radio_state == RSC_SETTLE)
		else $error("receive strobe ignored in idle");
	chk_tx_abort: assert property (radio_state == RSC_TX && cmd == 6'h01 |=> radio_state == RSC_SETTLE)
		else $error("receive strobe ignored in transmit");
	chk_tx_hold: assert property (radio_state == RSC_TX && !radio_ev.tx_pkt_done && cmd == 6'h00
		|=> radio_state == RSC_TX)
		else $error("transmit left early");
	chk_wake_sleep: assert property (radio_state == RSC_IDLE && cmd == 6'h10 |=> radio_state == RSC_SLEEP)
		else $error("wake strobe missed sleep");
	chk_sleep_exit: assert property (radio_state == RSC_SLEEP && cmd == 6'h00
		|=> radio_state inside {RSC_SLEEP, RSC_SETTLE})
		else $error("sleep left without cause");
	chk_ready_low_sleep: assert property (radio_ready_low == (radio_state == RSC_SLEEP))
		else $error("ready low disagrees with state");
	chk_flag_sticky: assert property (wake_wake_period_mantissa_flag && !clr0 |=> wake_wake_period_mantissa_flag)
		else $error("event flag lost");
	chk_pop_pulse: assert property (tx_byte_valid |-> $past(radio_ev.tx_byte_req))
		else $error("byte valid without pop");
endmodule
bind rsc_radio_ctrl rsc_monitor rsc_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.radio_ev(radio_ev), .radio_state(radio_state), .radio_ready_low(radio_ready_low),
	.wake_wake_period_mantissa_flag(wake_wake_period_mantissa_flag), .tx_byte_valid(tx_byte_valid));
`default_nettype wire

// ==== bench/tb_rsc_radio_ctrl.sv ====
// Self-checking testbench of the radio state controller
`timescale 1ns/100ps
`default_nettype none
module tb_rsc_radio_ctrl;
	import rsc_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, aux = 0, e;
	logic [7:0]  paddr = '0, tx_b;
	logic [31:0] pwdata = '0, prdata, q;
	logic        pready, pslverr, cal, rdy_low, wk0, wk1, rx_thr, tx_thr, tx_v;
	rsc_evt_s    ev, p;
	rsc_state_e  st;
	int          bad_count = 0, comparisons = 0, n, i;
	rsc_state_e  dest [4] = '{RSC_IDLE, RSC_FSTX, RSC_TX, RSC_RX};

	rsc_radio_model rsc_radio_model_i (.pclk(pclk), .ev(ev));
	rsc_radio_ctrl #(.T_IDLE_CAL(40), .T_CAL(30)) rsc_radio_ctrl_i (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .radio_ev(ev),
		.aux_clk_pin(aux), .radio_state(st), .calibrating(cal), .radio_ready_low(rdy_low),
		.wake_wake_period_mantissa_flag(wk0), .wake_second_event_timeout_flag(wk1), .rx_fifo_threshold_code(rx_thr),
		.tx_fifo_threshold_code(tx_thr), .tx_byte(tx_b), .tx_byte_valid(tx_v));

	initial forever #20 pclk = ~pclk;
	initial #7 forever #100 aux = ~aux;

	// ==========================================
	// Shared tasks
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			final_report();
		end
	endtask
	task automatic cmd(input int b);
		apb(1'b1, RSC_OFF_CMD, 32'h1 << b);
	endtask
	task automatic wait_st(input rsc_state_e s, input int lim);
		n = 0;
		while (st !== s && n < lim) begin
			@(negedge pclk);
			n++;
		end
		chk(st, s);
		if (st !== s) final_report();
	endtask
	task automatic near(input int t);
		chk(n >= t && n <= t + 2, 1'b1);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		chk({rdy_low, st}, {1'b1, RSC_SLEEP});
		apb(1'b0, RSC_OFF_STAT, 32'h0);
		chk(q, 32'h0200_0000);
		apb(1'b0, RSC_OFF_CFG, 32'h0);
		chk(q, {15'h0, RSC_CFG_RST});
		apb(1'b0, 8'h1c, 32'h0);
		chk(e, 1'b1);
		$display("reset test done");
	endtask
	task automatic t_after_rx();
		for (i = 0; i < 4; i++) begin
			apb(1'b1, RSC_OFF_CFG, 32'h0001_0000 | (i << 2));
			cmd(RSC_CMD_IDL);
			@(negedge pclk);
			chk(rdy_low, 1'b0);
			cmd(RSC_CMD_RX);
			wait_st(RSC_RX, 2400);
			near(2298);
			p = '0;
			p.rx_pkt_ok = 1'b1;
			rsc_radio_model_i.pulse(p);
			wait_st(dest[i], 400);
		end
		$display("after-receive test done");
	endtask
	task automatic t_switch();
		cmd(RSC_CMD_TX);
		wait_st(RSC_TX, 400);
		near(250);
		cmd(RSC_CMD_RX);
		wait_st(RSC_RX, 700);
		near(560);
		apb(1'b1, RSC_OFF_CFG, 32'h0001_004c);
		rsc_radio_model_i.level(1'b0, 1'b0, 1'b0);
		cmd(RSC_CMD_TX);
		repeat (300) @(negedge pclk);
		chk(st, RSC_RX);
		cmd(RSC_CMD_IDL);
		@(negedge pclk);
		chk(st, RSC_IDLE);
		$display("switch test done");
	endtask
	task automatic t_timeout();
		apb(1'b1, RSC_OFF_RXT, 32'd100);
		apb(1'b1, RSC_OFF_CFG, 32'h0001_0002);
		cmd(RSC_CMD_RX);
		wait_st(RSC_RX, 2400);
		wait_st(RSC_SETTLE, 150);
		near(100);
		chk(cal, 1'b1);
		wait_st(RSC_IDLE, 60);
		near(30);
		$display("timeout test done");
	endtask
	task automatic t_term();
		apb(1'b1, RSC_OFF_CFG, 32'h0001_0200);
		cmd(RSC_CMD_RX);
		wait_st(RSC_RX, 2400);
		p = '0;
		p.cs_valid = 1'b1;
		rsc_radio_model_i.pulse(p);
		wait_st(RSC_IDLE, 20);
		apb(1'b1, RSC_OFF_CFG, 32'h0001_0001);
		rsc_radio_model_i.level(1'b0, 1'b0, 1'b1);
		cmd(RSC_CMD_RX);
		wait_st(RSC_RX, 100);
		near(40);
		repeat (150) @(negedge pclk);
		chk(st, RSC_RX);
		cmd(RSC_CMD_IDL);
		@(negedge pclk);
		chk({cal, st}, {1'b0, RSC_IDLE});
		cmd(RSC_CMD_CAL);
		@(negedge pclk);
		chk(cal, 1'b1);
		wait_st(RSC_IDLE, 60);
		near(30);
		cmd(RSC_CMD_SYN);
		wait_st(RSC_FSTX, 100);
		near(40);
		cmd(RSC_CMD_IDL);
		rsc_radio_model_i.level(1'b0, 1'b0, 1'b0);
		$display("termination test done");
	endtask
	task automatic t_fifo();
		for (i = 0; i < 4; i++) begin
			p = '0;
			p.rx_byte_valid = 1'b1;
			p.rx_byte = 8'h10 + 8'(i);
			@(negedge pclk);
			if (i == 3) chk(rx_thr, 1'b0);
			rsc_radio_model_i.pulse(p);
		end
		repeat (2) @(negedge pclk);
		chk(rx_thr, 1'b1);
		apb(1'b0, RSC_OFF_DATA, 32'h0);
		chk(q[7:0], 8'h10);
		apb(1'b0, RSC_OFF_SBYTE, 32'h0);
		chk(q[7:0], 8'h04);
		for (i = 0; i < 60; i++) apb(1'b1, RSC_OFF_DATA, 32'h5a);
		repeat (2) @(negedge pclk);
		chk(tx_thr, 1'b0);
		apb(1'b0, RSC_OFF_SBYTE, 32'h0);
		chk(q[7:0], 8'hbb);
		apb(1'b1, RSC_OFF_DATA, 32'h5a);
		repeat (2) @(negedge pclk);
		chk(tx_thr, 1'b1);
		p = '0;
		p.tx_byte_req = 1'b1;
		rsc_radio_model_i.pulse(p);
		@(negedge pclk);
		chk(tx_b, 8'h5a);
		chk(tx_v, 1'b1);
		$display("fifo test done");
	endtask
	task automatic t_wake();
		cmd(RSC_CMD_IDL);
		apb(1'b1, RSC_OFF_WAKE, 32'h0002_0190);
		cmd(RSC_CMD_WOR);
		@(negedge pclk);
		chk(st, RSC_SLEEP);
		apb(1'b0, RSC_OFF_CFG, 32'h0);
		chk(q[RSC_CFG_PD], 1'b0);
		wait_st(RSC_RX, 5000);
		chk({wk1, wk0}, 2'h3);
		wait_st(RSC_SLEEP, 150);
		near(100);
		apb(1'b1, RSC_OFF_STAT, 32'h0000_0030);
		@(negedge pclk);
		chk({wk1, wk0}, 2'h0);
		$display("wake test done");
	endtask

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_after_rx();
		t_switch();
		t_timeout();
		t_term();
		t_fifo();
		t_wake();
		final_report();
	end
endmodule
`default_nettype wire
